// ===== logic/spsf_pkg.sv
// Purpose: constants for the serial port status flag block
// Assumes: 8-bit register port, one 20 MHz core clock
// Notes:   offsets are register port addresses
package spsf_pkg;

  // register port addresses
  localparam logic [7:0] SPSF_ADDR_CTRL_STATUS = 8'h98;
  localparam logic [7:0] SPSF_ADDR_INT_STATUS  = 8'h99;
  localparam logic [7:0] SPSF_ADDR_INT_MASK    = 8'h9A;

  // bit positions inside the control/status register
  localparam int SPSF_BIT_RX_DONE   = 0;
  localparam int SPSF_BIT_TX_DONE   = 1;
  localparam int SPSF_BIT_RX_NINTH  = 2;
  localparam int SPSF_BIT_TX_NINTH  = 3;
  localparam int SPSF_BIT_RX_ENABLE = 4;
  localparam int SPSF_BIT_MP_CMP    = 5;
  localparam int SPSF_BIT_MODE_LOW  = 6;
  localparam int SPSF_BIT_MODE_HIGH = 7;

  // bit positions inside the interrupt status and mask registers
  localparam int SPSF_INT_TX = 0;
  localparam int SPSF_INT_RX = 1;

  // values after reset
  localparam logic [7:0] SPSF_RST_CTRL_STATUS = 8'h00;
  localparam logic [1:0] SPSF_RST_INT_STATUS  = 2'h0;
  localparam logic [1:0] SPSF_RST_INT_MASK    = 2'h0;
  localparam logic [7:0] SPSF_RST_RDATA       = 8'h00;

  // index of the last bit of a frame, or of the ninth data bit, counted from 0 at the first bit
  localparam logic [3:0] SPSF_POS_MODE0_LAST  = 4'h7;  // eighth data bit
  localparam logic [3:0] SPSF_POS_MODE1_STOP  = 4'h9;  // start+8+stop
  localparam logic [3:0] SPSF_POS_NINE_DATA   = 4'h9;  // ninth data bit
  localparam logic [3:0] SPSF_POS_NINE_STOP   = 4'hA;  // start+9+stop

  // serial modes, encoded {mode_high, mode_low}
  typedef enum logic [1:0] {
    SPSF_MODE_SHIFT  = 2'h0,
    SPSF_MODE_UART8  = 2'h1,
    SPSF_MODE_UART9F = 2'h2,
    SPSF_MODE_UART9V = 2'h3
  } spsf_mode_t;

endpackage

// ===== logic/spsf_flags.sv
// Purpose: control/status register and completion flags of a serial port
// Assumes: bit events come from shift logic on the same clock, one-cycle
//          pulses with the index of the bit just shifted
// Notes:   interrupt status/mask pair is an extra layer over the flags
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

//Function
// - mode 0: transmit-done flag sets after the eighth data bit shifts out.
// - other modes: transmit-done flag sets after the frame's last bit is sent.
// - modes 2 and 3: ninth received bit goes into received_ninth_bit.
// - mode 1 with compare off: received stop bit goes into received_ninth_bit.
module spsf_flags
  import spsf_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output      logic [7:0] reg_rdata,
  // transmit shifter events
  input  wire logic       tx_bit_sent,
  input  wire logic [3:0] tx_bit_pos,
  // receive shifter events
  input  wire logic       rx_bit_valid,
  input  wire logic [3:0] rx_bit_pos,
  input  wire logic       rx_bit_value,
  // settings toward the shifters
  output      logic [1:0] serial_mode,
  output      logic       multiprocessor_compare_enable,
  output      logic       receive_enable,
  output      logic       transmit_ninth_bit,
  output      logic       transmit_done_flag,
  output      logic       receive_done_flag,
  // interrupt
  output      logic       irq
);

  // register state and the values it takes at the next edge
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [1:0] int_status_reg;
  logic [1:0] int_status_next;
  logic [1:0] int_mask_reg;
  logic [1:0] int_mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       irq_reg;
  logic       irq_next;

  // events decoded in the current cycle
  logic       tx_done_evt;
  logic       rx_done_evt;
  logic       ninth_load;
  logic       ninth_value;
  logic       ninth_now;
  spsf_mode_t mode;

  // strobe aimed at one register address; shared by every write decode
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  // frame position of the last transmitted bit for a mode
  function automatic logic [3:0] last_tx_pos(input spsf_mode_t m);
    case (m)
      SPSF_MODE_SHIFT: last_tx_pos = SPSF_POS_MODE0_LAST;
      SPSF_MODE_UART8: last_tx_pos = SPSF_POS_MODE1_STOP;
      default:         last_tx_pos = SPSF_POS_NINE_STOP;
    endcase
  endfunction

  assign mode = spsf_mode_t'({ctrl_reg[SPSF_BIT_MODE_HIGH],
                              ctrl_reg[SPSF_BIT_MODE_LOW]});

  // transmit completion event
  // mode 0 counts data bits only, the other modes count the whole frame
  always_comb begin
    tx_done_evt = 1'b0;
    if (tx_bit_sent && tx_bit_pos == last_tx_pos(mode)) begin
      if (mode == SPSF_MODE_SHIFT) begin
        tx_done_evt = 1'b1;
      end else begin
        tx_done_evt = 1'b1;
      end
    end
  end

  // receive ninth bit capture and completion event; receiver off ignores
  // the line entirely so a stray frame cannot disturb the status bits
  // the ninth bit stored at position 9 gates completion at position 10,
  // so the shifter may send those events in consecutive cycles
  always_comb begin
    rx_done_evt = 1'b0;
    ninth_load  = 1'b0;
    ninth_value = 1'b0;
    ninth_now   = ctrl_reg[SPSF_BIT_RX_NINTH];
    if (rx_bit_valid && ctrl_reg[SPSF_BIT_RX_ENABLE]) begin
      case (mode)
        SPSF_MODE_SHIFT: begin
          // no ninth bit in shift mode; done after eighth bit
          rx_done_evt = (rx_bit_pos == SPSF_POS_MODE0_LAST);
        end
        SPSF_MODE_UART8: begin
          if (rx_bit_pos == SPSF_POS_MODE1_STOP) begin
            if (!ctrl_reg[SPSF_BIT_MP_CMP]) begin
              ninth_load  = 1'b1;
              ninth_value = rx_bit_value;
              rx_done_evt = 1'b1;
            end else begin
              // compare on: only a valid stop bit completes the frame
              rx_done_evt = rx_bit_value;
            end
          end
        end
        SPSF_MODE_UART9F, SPSF_MODE_UART9V: begin
          if (rx_bit_pos == SPSF_POS_NINE_DATA) begin
            ninth_load  = 1'b1;
            ninth_value = rx_bit_value;
          end else if (rx_bit_pos == SPSF_POS_NINE_STOP) begin
            // compare on filters out frames whose ninth bit is zero
            rx_done_evt = ninth_now | ~ctrl_reg[SPSF_BIT_MP_CMP];
          end
        end
        default: begin
          rx_done_evt = 1'b0;
        end
      endcase
    end
  end

  // control/status register next value; hardware set beats a same-cycle
  // software clear so no completion is lost
  // software may also set a flag by writing it, but that raises no
  // interrupt, as only completion events set interrupt status; the price is no protection against slips
  always_comb begin
    ctrl_next = ctrl_reg;
    if (addr_hit(reg_write, reg_addr, SPSF_ADDR_CTRL_STATUS)) begin
      ctrl_next = reg_wdata;
    end
    if (ninth_load) begin
      ctrl_next[SPSF_BIT_RX_NINTH] = ninth_value;
    end
    if (tx_done_evt) begin
      ctrl_next[SPSF_BIT_TX_DONE] = 1'b1;
    end
    if (rx_done_evt) begin
      ctrl_next[SPSF_BIT_RX_DONE] = 1'b1;
    end
  end

  // interrupt status (write one to clear, set wins) and mask
  // write-one-to-clear lets software acknowledge one source without a
  // read-modify-write race against the other source
  always_comb begin
    int_status_next = int_status_reg;
    int_mask_next   = int_mask_reg;
    if (addr_hit(reg_write, reg_addr, SPSF_ADDR_INT_STATUS)) begin
      int_status_next = int_status_reg & ~reg_wdata[1:0];
    end
    if (addr_hit(reg_write, reg_addr, SPSF_ADDR_INT_MASK)) begin
      int_mask_next = reg_wdata[1:0];
    end
    if (tx_done_evt) begin
      int_status_next[SPSF_INT_TX] = 1'b1;
    end
    if (rx_done_evt) begin
      int_status_next[SPSF_INT_RX] = 1'b1;
    end
    // built from the next values so the flopped output tracks the
    // unmasked status bits in the same cycle rather than one behind
    irq_next = |(int_status_next & int_mask_next);
  end

  // read data, valid in the cycle after the read strobe only
  // idle cycles and unmapped addresses both read zero, which keeps the
  // bus quiet between reads
  always_comb begin
    rdata_next = SPSF_RST_RDATA;
    if (reg_read) begin
      case (reg_addr)
        SPSF_ADDR_CTRL_STATUS: rdata_next = ctrl_reg;
        SPSF_ADDR_INT_STATUS:  rdata_next = {6'h00, int_status_reg};
        SPSF_ADDR_INT_MASK:    rdata_next = {6'h00, int_mask_reg};
        default:               rdata_next = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // state registers
  // reset clears every flag so no stale interrupt fires at start
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg       <= SPSF_RST_CTRL_STATUS;
      int_status_reg <= SPSF_RST_INT_STATUS;
      int_mask_reg   <= SPSF_RST_INT_MASK;
      rdata_reg      <= SPSF_RST_RDATA;
      irq_reg        <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      int_status_reg <= int_status_next;
      int_mask_reg   <= int_mask_next;
      rdata_reg      <= rdata_next;
      irq_reg        <= irq_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata                     = rdata_reg;
  assign serial_mode                   = {ctrl_reg[SPSF_BIT_MODE_HIGH],
                                          ctrl_reg[SPSF_BIT_MODE_LOW]};
  assign multiprocessor_compare_enable = ctrl_reg[SPSF_BIT_MP_CMP];
  assign receive_enable                = ctrl_reg[SPSF_BIT_RX_ENABLE];
  assign transmit_ninth_bit            = ctrl_reg[SPSF_BIT_TX_NINTH];
  assign transmit_done_flag            = ctrl_reg[SPSF_BIT_TX_DONE];
  assign receive_done_flag             = ctrl_reg[SPSF_BIT_RX_DONE];
  assign irq                           = irq_reg;

endmodule

// ===== dv/spsf_flags_checker.sv
// Purpose: port-level checks of the serial completion flags
// Assumes: ctrl register at SPSF_ADDR_CTRL_STATUS
// Notes:   flag set is checked one cycle after the last-bit event
`timescale 1ns/1ps
module spsf_flags_checker
  import spsf_pkg::*;
(
  // clock, reset, bus and events
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_bit_sent,
  input wire logic [3:0] tx_bit_pos,
  input wire logic       rx_bit_valid,
  input wire logic [3:0] rx_bit_pos,
  input wire logic       rx_bit_value,
  // observed flags and settings
  input wire logic [1:0] serial_mode,
  input wire logic       multiprocessor_compare_enable,
  input wire logic       receive_enable,
  input wire logic       transmit_done_flag,
  input wire logic       receive_done_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // a ctrl write is the only thing allowed to drop a flag
  logic ctrl_wr;
  assign ctrl_wr = reg_write && reg_addr == SPSF_ADDR_CTRL_STATUS;
  // reference copy of the received ninth bit, rebuilt from port events;
  // a line event beats a same-cycle register write
  logic rb8_model;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rb8_model <= 1'b0;
    end else if (rx_bit_valid && receive_enable && rx_bit_pos == 4'h9 &&
                 (serial_mode[1] ||
                  (serial_mode == 2'h1 && !multiprocessor_compare_enable)))
    begin
      rb8_model <= rx_bit_value;
    end else if (ctrl_wr) begin
      rb8_model <= reg_wdata[SPSF_BIT_RX_NINTH];
    end
  end
  property p_rx_ninth;
    reg_read && reg_addr == SPSF_ADDR_CTRL_STATUS
      |=> reg_rdata[SPSF_BIT_RX_NINTH] == $past(rb8_model);
  endproperty
  a_rx_ninth: assert property (p_rx_ninth)
    else $error("received ninth bit differs from line events");
  property p_tx_mode0;
    tx_bit_sent && tx_bit_pos == 4'h7 && serial_mode == 2'h0
      |=> transmit_done_flag;
  endproperty
  a_tx_mode0: assert property (p_tx_mode0)
    else $error("transmit flag missing after mode 0 byte");
  property p_tx_frame;
    tx_bit_sent && serial_mode != 2'h0 &&
      tx_bit_pos == (serial_mode == 2'h1 ? 4'h9 : 4'hA)
      |=> transmit_done_flag;
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("transmit flag missing after frame end");
  property p_tx_keep;
    transmit_done_flag && !ctrl_wr |=> transmit_done_flag;
  endproperty
  a_tx_keep: assert property (p_tx_keep)
    else $error("transmit flag dropped without a write");
  property p_rx_keep;
    receive_done_flag && !ctrl_wr |=> receive_done_flag;
  endproperty
  a_rx_keep: assert property (p_rx_keep)
    else $error("receive flag dropped without a write");
endmodule
bind spsf_flags spsf_flags_checker u_chk (.mclk(mclk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_bit_sent(tx_bit_sent),
  .tx_bit_pos(tx_bit_pos), .rx_bit_valid(rx_bit_valid),
  .rx_bit_pos(rx_bit_pos), .rx_bit_value(rx_bit_value),
  .serial_mode(serial_mode),
  .multiprocessor_compare_enable(multiprocessor_compare_enable),
  .receive_enable(receive_enable),
  .transmit_done_flag(transmit_done_flag),
  .receive_done_flag(receive_done_flag));

// ===== dv/spsf_line_model.sv
// Purpose: far-side serial device seen as shifter bit events
// Assumes: one bit every two cycles, tx and rx frames side by side
// Notes:   idle value line flips so a stale bit is never mistaken
`timescale 1ns/1ps
module spsf_line_model (
  // clock
  input wire logic       mclk,
  // bit events toward the flag block
  output     logic       bit_strobe,
  output     logic [3:0] bit_pos,
  output     logic       bit_value
);
  initial begin
    bit_strobe = 1'b0;
    bit_pos    = 4'h0;
    bit_value  = 1'b0;
  end
  // bit 9 carries the ninth data bit or the mode 1 stop bit
  task automatic frame(input logic [3:0] last, input logic ninth);
    for (int i = 0; i <= last; i++) begin
      @(posedge mclk);
      bit_strobe <= 1'b1;
      bit_pos    <= 4'(i);
      bit_value  <= (i == 9) ? ninth : 1'b1;
      @(posedge mclk);
      bit_strobe <= 1'b0;
      bit_value  <= ~bit_value;
    end
  endtask
endmodule

// ===== dv/serial_port_status_flags_bench.sv
// Purpose: register-level tests of the serial completion flags
// Assumes: 20 MHz mclk, events from the line model
// Notes:   every mode, compare on and off, both ninth-bit values
`timescale 1ns/1ps
module serial_port_status_flags_bench
  import spsf_pkg::*;
;
  logic       mclk = 1'b0, arst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, exp;
  logic [3:0] pos;
  logic [1:0] serial_mode;
  logic       strb, val, mpc, ren, tnb, tdf, rdf, irq;
  int         fails = 0, n_compared = 0, m, nb, cmp;
  // the same events feed both shifter sides
  spsf_line_model u_line (.mclk(mclk), .bit_strobe(strb), .bit_pos(pos),
    .bit_value(val));
  spsf_flags u_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_bit_sent(strb), .tx_bit_pos(pos),
    .rx_bit_valid(strb), .rx_bit_pos(pos), .rx_bit_value(val),
    .serial_mode(serial_mode), .multiprocessor_compare_enable(mpc),
    .receive_enable(ren), .transmit_ninth_bit(tnb),
    .transmit_done_flag(tdf), .receive_done_flag(rdf), .irq(irq));
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, want);
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rd(SPSF_ADDR_CTRL_STATUS, 8'h00);
    rd(SPSF_ADDR_INT_STATUS, 8'h00);
    rd(SPSF_ADDR_INT_MASK, 8'h00);
    rd(8'h55, 8'h00);
    wr(SPSF_ADDR_INT_MASK, 8'h03);
    // k: mode in bits 1:0, ninth value in bit 2, compare on in bit 3
    for (int k = 0; k < 16; k++) begin
      m = k % 4;
      nb = (k / 4) % 2;
      cmp = k / 8;
      exp = 8'(m << 6) | 8'(cmp << 5) | 8'(nb << 3) | 8'h10;
      wr(SPSF_ADDR_CTRL_STATUS, exp);
      // settings show once the write has landed, just after the edge
      #1 chk({serial_mode, mpc, ren, tnb, 1'b0, tdf, rdf}, exp);
      u_line.frame(m == 0 ? 4'h7 : m == 1 ? 4'h9 : 4'hA, 1'(nb));
      // ninth bit: modes 2 and 3 always, mode 1 only with compare off
      if (m >= 2 || (m == 1 && cmp == 0))
        exp = exp | 8'(nb << 2);
      exp = exp | 8'h02;
      exp = exp | 8'((cmp == 0 || m == 0 || nb == 1) ? 1 : 0);
      repeat (20) @(posedge mclk);
      chk({6'h00, tdf, rdf}, {6'h00, exp[1:0]});
      rd(SPSF_ADDR_CTRL_STATUS, exp);
      chk(8'(irq), 8'h01);
      wr(SPSF_ADDR_INT_STATUS, 8'h03);
      wr(SPSF_ADDR_CTRL_STATUS, 8'h00);
      rd(SPSF_ADDR_CTRL_STATUS, 8'h00);
      rd(SPSF_ADDR_INT_STATUS, 8'h00);
      chk(8'(irq), 8'h00);
      $display("test %0d done", k);
    end
    // receiver off: the frame completes transmit only, rx bits untouched
    wr(SPSF_ADDR_CTRL_STATUS, 8'h40);
    u_line.frame(4'h9, 1'b1);
    repeat (4) @(posedge mclk);
    rd(SPSF_ADDR_CTRL_STATUS, 8'h42);
    $display("test receiver off done");
    complete_run();
  end
endmodule
